/* File: src/lcd_segment_controller.sv */
/*
 * Segment display controller: mode register and display memory on an
 * AHB-Lite slave, clock selection, frame timing and backplane scan.
 * Assumes STOP_IN comes from core logic on MCLK_IN; the auxiliary
 * oscillator and the oscillator fail flag arrive from outside.
 */
// The implementer's own choice: the AHB-Lite register port.
// Function
// - Six bytes per backplane, three unused LSBs
// - Set bit drives element on
// - Reset leaves display memory untouched
// - Unused backplane bytes stay plain storage
// - Stop on main clock grounds all lines
// - Auxiliary source keeps display running in stop
// - Source change applies at frame end
// - Source code zero turns display off
// - Codes 010, 111 reserved; 001 auxiliary
// - Mode fields: ratio, source, frame divider
// - Ratio field sets scanned backplane count
// - Frame divider codes divide reference clock
// - Ratio 00 four, else code backplanes
// - Source codes 3-6 divide by 32-256
// - Frame rate is base over backplanes
// - Oscillator failure grounds all lines
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_controller
    import lcd_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // System
    input wire logic STOP_IN,
    input wire logic AUX_OSC_IN,
    input wire logic OSC_FAIL_IN,
    // Panel
    output logic [44:0] SEG_OUT,
    output logic [3:0] BP_OUT,
    output logic DISPLAY_ON_OUT
);
    ram_port_if rif ();

    display_ram u_ram (
        .clk_in (MCLK_IN),
        .rif (rif.mem)
    );

    // ------------------------------------------------------------
    // Bus address and data phases
    // ------------------------------------------------------------
    logic take;
    logic [7:0] addr_idx;
    logic addr_ok;
    logic [7:0] addr_reg;
    logic dp_write_reg;
    logic [1:0] rd_stage_reg;
    logic hit_mode;
    logic hit_ram;
    logic [7:0] ram_off;
    logic [7:0] read_byte;
    logic [7:0] mode_reg;

    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign addr_ok = (HADDR_IN[31:10] == 22'h0) && (HADDR_IN[1:0] == 2'h0);
    assign addr_idx = addr_ok ? HADDR_IN[9:2] : 8'h00;
    assign hit_mode = (addr_reg == MODE_IDX);
    assign hit_ram = (addr_reg >= RAM_FIRST_IDX) && (addr_reg <= RAM_LAST_IDX);
    assign ram_off = addr_reg - RAM_FIRST_IDX;
    assign rif.bus_addr = hit_ram ? ram_off[4:0] : 5'h00;
    assign rif.wr_en = dp_write_reg && hit_ram;
    assign rif.wr_data = HWDATA_IN[7:0];
    assign read_byte = hit_mode ? mode_reg : (hit_ram ? rif.rd_data : 8'h00);

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            addr_reg <= 8'h00;
            dp_write_reg <= 1'b0;
            rd_stage_reg <= 2'h0;
            HREADYOUT_OUT <= 1'b1;
            HRDATA_OUT <= 32'h0;
            HRESP_OUT <= 1'b0;
        end else begin
            dp_write_reg <= take && HWRITE_IN;
            if (take) begin
                addr_reg <= addr_idx;
            end
            if (take && !HWRITE_IN) begin
                rd_stage_reg <= 2'h1;
                HREADYOUT_OUT <= 1'b0;
            end else if (rd_stage_reg == 2'h1) begin
                rd_stage_reg <= 2'h2;
            end else if (rd_stage_reg == 2'h2) begin
                rd_stage_reg <= 2'h0;
                HRDATA_OUT <= {24'h0, read_byte};
                HREADYOUT_OUT <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    logic [1:0] mux_sel;
    logic [2:0] src_sel;
    logic [2:0] fdiv_sel;

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            mode_reg <= MODE_RESET;
        end else if (dp_write_reg && hit_mode) begin
            mode_reg <= HWDATA_IN[7:0];
        end
    end

    assign mux_sel = mode_reg[MUX_LSB +: 2];
    assign src_sel = mode_reg[SRC_LSB +: 3];
    assign fdiv_sel = mode_reg[FDIV_LSB +: 3];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic aux_s1_reg;
    logic aux_s2_reg;
    logic aux_s3_reg;
    logic fail_s1_reg;
    logic fail_s2_reg;
    logic aux_edge;

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            aux_s1_reg <= 1'b0;
            aux_s2_reg <= 1'b0;
            aux_s3_reg <= 1'b0;
            fail_s1_reg <= 1'b0;
            fail_s2_reg <= 1'b0;
        end else begin
            aux_s1_reg <= AUX_OSC_IN;
            aux_s2_reg <= aux_s1_reg;
            aux_s3_reg <= aux_s2_reg;
            fail_s1_reg <= OSC_FAIL_IN;
            fail_s2_reg <= fail_s1_reg;
        end
    end

    assign aux_edge = aux_s2_reg && !aux_s3_reg;

    // ------------------------------------------------------------
    // Clock source and run condition
    // ------------------------------------------------------------
    logic [2:0] active_src_reg;
    logic src_ok;
    logic stop_off;
    logic run;
    logic use_aux;
    logic pre_tick;
    logic ref_tick;
    logic slot_tick;
    logic frame_end;
    logic [2:0] bp_count;
    logic [1:0] last_slot;
    logic [1:0] slot_reg;
    logic [1:0] slot_q_reg;
    disp_state_t state_reg;
    disp_state_t state_next;

    assign src_ok = (active_src_reg != SRC_OFF) && (active_src_reg != SRC_RES_A)
        && (active_src_reg != SRC_RES_B);
    assign use_aux = (active_src_reg == SRC_AUX);
    assign stop_off = STOP_IN && !use_aux;
    assign run = src_ok && (fdiv_sel != FDIV_RES) && !fail_s2_reg && !stop_off;
    assign state_next = run ? ST_SCAN : ST_OFF;

    assign bp_count = (mux_sel == MUX_FOUR) ? BP_FOUR : {1'b0, mux_sel};
    assign last_slot = 2'(bp_count - 3'h1);
    assign frame_end = slot_tick && (slot_reg >= last_slot);
    assign ref_tick = use_aux ? aux_edge : pre_tick;

    tick_divider #(.W(DIV_W)) u_prescale (
        .clk_in (MCLK_IN),
        .rst_in (RST_IN),
        .clr_in (state_reg == ST_OFF || use_aux),
        .tick_in (1'b1),
        .div_in (pre_div(active_src_reg)),
        .tick_out (pre_tick)
    );

    tick_divider #(.W(DIV_W)) u_frame (
        .clk_in (MCLK_IN),
        .rst_in (RST_IN),
        .clr_in (state_reg == ST_OFF),
        .tick_in (ref_tick),
        .div_in (frame_div(fdiv_sel)),
        .tick_out (slot_tick)
    );

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            active_src_reg <= SRC_OFF;
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
            if (frame_end || !src_ok) begin
                active_src_reg <= src_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // Backplane scan and panel outputs
    // ------------------------------------------------------------
    assign rif.row_sel = slot_reg;

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN || state_reg == ST_OFF) begin
            slot_reg <= 2'h0;
        end else if (slot_tick) begin
            slot_reg <= (slot_reg >= last_slot) ? 2'h0 : slot_reg + 2'h1;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            slot_q_reg <= 2'h0;
            SEG_OUT <= 45'h0;
            BP_OUT <= 4'h0;
            DISPLAY_ON_OUT <= 1'b0;
        end else begin
            slot_q_reg <= slot_reg;
            DISPLAY_ON_OUT <= run && state_reg == ST_SCAN;
            if (run && state_reg == ST_SCAN) begin
                SEG_OUT <= rif.row_data[ROW_BITS-1:UNUSED_LSBS];
                BP_OUT <= 4'h1 << slot_q_reg;
            end else begin
                SEG_OUT <= 45'h0;
                BP_OUT <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    property p_mode_write;
        dp_write_reg && hit_mode |=> mode_reg == $past(HWDATA_IN[7:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_stop_ground;
        stop_off ##1 stop_off |=> SEG_OUT == 45'h0 && BP_OUT == 4'h0 && !DISPLAY_ON_OUT;
    endproperty
    a_stop_ground: assert property (p_stop_ground) else $error("stop left lines on");

    property p_aux_stop;
        STOP_IN && use_aux && DISPLAY_ON_OUT && !fail_s2_reg && fdiv_sel != FDIV_RES
            |=> DISPLAY_ON_OUT;
    endproperty
    a_aux_stop: assert property (p_aux_stop) else $error("aux display stopped");

    property p_src_switch;
        active_src_reg != $past(active_src_reg) |-> $past(frame_end) || $past(!src_ok);
    endproperty
    a_src_switch: assert property (p_src_switch) else $error("source changed mid frame");

    property p_src_zero;
        active_src_reg == SRC_OFF |=> !DISPLAY_ON_OUT && BP_OUT == 4'h0;
    endproperty
    a_src_zero: assert property (p_src_zero) else $error("display on with clock off");

    property p_src_reserved;
        (active_src_reg == SRC_RES_A || active_src_reg == SRC_RES_B) |=> !DISPLAY_ON_OUT;
    endproperty
    a_src_reserved: assert property (p_src_reserved) else $error("reserved source ran");

    property p_bp_range;
        BP_OUT != 4'h0 |-> (BP_OUT & ~((4'h1 << bp_count) - 4'h1)) == 4'h0 && $onehot(BP_OUT);
    endproperty
    a_bp_range: assert property (p_bp_range) else $error("backplane out of range");

    property p_fail_ground;
        fail_s2_reg |=> SEG_OUT == 45'h0 && BP_OUT == 4'h0;
    endproperty
    a_fail_ground: assert property (p_fail_ground) else $error("fail left lines on");

    property p_slot_order;
        slot_tick && slot_reg < last_slot && state_reg == ST_SCAN
            |=> slot_reg == $past(slot_reg) + 2'h1;
    endproperty
    a_slot_order: assert property (p_slot_order) else $error("slot order broken");

    property p_frame_end;
        frame_end && state_reg == ST_SCAN |=> slot_reg == 2'h0;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame did not wrap");

    property p_read_wait;
        take && !HWRITE_IN |=> !HREADYOUT_OUT ##1 !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read timing wrong");

    c_aux_stop: cover property (STOP_IN && use_aux && DISPLAY_ON_OUT);
    c_frame_four: cover property (frame_end && bp_count == BP_FOUR);
    c_read_done: cover property (rd_stage_reg == 2'h2 && hit_ram);
endmodule
`default_nettype wire

/* File: common/lcd_pkg.sv */
/*
 * Constants for the segment display controller: register indices,
 * mode field layout, clock source codes and divider tables.
 * Assumes a byte-wide register space reached through 32-bit words.
 */
package lcd_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_IDX = 8'hDC;
    localparam logic [7:0] RAM_FIRST_IDX = 8'hE0;
    localparam logic [7:0] RAM_LAST_IDX = 8'hF7;
    localparam int RAM_BYTES = 24;
    localparam int ROW_BYTES = 6;
    localparam int ROW_BITS = 48;
    localparam int UNUSED_LSBS = 3;
    localparam int BP_MAX = 4;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MUX_LSB = 6;
    localparam int SRC_LSB = 3;
    localparam int FDIV_LSB = 0;
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_AUX = 3'h1;
    localparam logic [2:0] SRC_RES_A = 3'h2;
    localparam logic [2:0] SRC_RES_B = 3'h7;
    localparam logic [2:0] FDIV_RES = 3'h7;
    localparam logic [1:0] MUX_FOUR = 2'h0;
    localparam logic [2:0] BP_FOUR = 3'h4;

    // ------------------------------------------------------------
    // Divider tables
    // ------------------------------------------------------------
    localparam int DIV_W = 10;
    localparam logic [9:0] PRE_DIV_3 = 10'd32;
    localparam logic [9:0] PRE_DIV_4 = 10'd64;
    localparam logic [9:0] PRE_DIV_5 = 10'd128;
    localparam logic [9:0] PRE_DIV_6 = 10'd256;
    localparam logic [9:0] FDIV_0 = 10'd512;
    localparam logic [9:0] FDIV_1 = 10'd386;
    localparam logic [9:0] FDIV_2 = 10'd256;
    localparam logic [9:0] FDIV_3 = 10'd192;
    localparam logic [9:0] FDIV_4 = 10'd128;
    localparam logic [9:0] FDIV_5 = 10'd96;
    localparam logic [9:0] FDIV_6 = 10'd64;

    typedef enum logic {ST_OFF = 1'b0, ST_SCAN = 1'b1} disp_state_t;

    function automatic logic [9:0] pre_div(input logic [2:0] code);
        case (code)
            3'h4: pre_div = PRE_DIV_4;
            3'h5: pre_div = PRE_DIV_5;
            3'h6: pre_div = PRE_DIV_6;
            default: pre_div = PRE_DIV_3;
        endcase
    endfunction

    function automatic logic [9:0] frame_div(input logic [2:0] code);
        case (code)
            3'h1: frame_div = FDIV_1;
            3'h2: frame_div = FDIV_2;
            3'h3: frame_div = FDIV_3;
            3'h4: frame_div = FDIV_4;
            3'h5: frame_div = FDIV_5;
            3'h6: frame_div = FDIV_6;
            default: frame_div = FDIV_0;
        endcase
    endfunction
endpackage

/* File: common/ram_port_if.sv */
/*
 * Port bundle between the controller and its display memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
    logic [4:0] bus_addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [1:0] row_sel;
    logic [47:0] row_data;
    modport ctrl (output bus_addr, output wr_en, output wr_data, output row_sel,
                  input rd_data, input row_data);
    modport mem (input bus_addr, input wr_en, input wr_data, input row_sel,
                 output rd_data, output row_data);
endinterface
`default_nettype wire

/* File: src/display_ram.sv */
/*
 * Display memory: 24 bytes, one byte port for the bus, one row port
 * for the scanner returning all six bytes of one backplane.
 * Assumes bus_addr stays below 24; both read ports are registered.
 */
`timescale 1ns/1ps
`default_nettype none
module display_ram
    import lcd_pkg::*;
(
    input wire logic clk_in,
    ram_port_if.mem rif
);
    logic [7:0] mem [RAM_BYTES];
    logic [4:0] base;

    assign base = 5'({3'h0, rif.row_sel} * 5'(ROW_BYTES));

    // ------------------------------------------------------------
    // Storage, no reset on purpose
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rif.wr_en) begin
            mem[rif.bus_addr] <= rif.wr_data;
        end
        rif.rd_data <= mem[rif.bus_addr];
    end

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < ROW_BYTES; i++) begin
            rif.row_data[8*i +: 8] <= mem[base + 5'(i)];
        end
    end
endmodule
`default_nettype wire

/* File: src/tick_divider.sv */
/*
 * Tick divider: emits one registered pulse every div input ticks.
 * Assumes div is at least two; clr holds the count at zero.
 */
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int W = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clr_in,
    input wire logic tick_in,
    input wire logic [W-1:0] div_in,
    output logic tick_out
);
    logic [W-1:0] count_reg;
    logic wrap;

    assign wrap = tick_in && (count_reg >= div_in - W'(1));

    always_ff @(posedge clk_in) begin
        if (rst_in || clr_in) begin
            count_reg <= '0;
            tick_out <= 1'b0;
        end else begin
            count_reg <= wrap ? '0 : (tick_in ? count_reg + W'(1) : count_reg);
            tick_out <= wrap;
        end
    end

    property p_div_period;
        @(posedge clk_in) disable iff (rst_in || clr_in)
        tick_in && count_reg == div_in - W'(1) |=> tick_out;
    endproperty
    a_div_period: assert property (p_div_period) else $error("divider missed wrap");

    property p_div_spacing;
        @(posedge clk_in) disable iff (rst_in || clr_in)
        tick_out |-> count_reg == '0;
    endproperty
    a_div_spacing: assert property (p_div_spacing) else $error("divider count off");
endmodule
`default_nettype wire

/* File: sim/panel_model.sv */
/*
 * Panel model: watches the segment and backplane lines and flags any
 * drive that would leave a DC bias across the glass.
 * Assumes registered panel outputs on the controller clock.
 */
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    // Clock
    input wire logic clk_in,
    // Electrodes
    input wire logic [44:0] seg_in,
    input wire logic [3:0] bp_in,
    // Status
    output logic fault_out
);
    initial fault_out = 1'b0;

    // Segments driven with no plate, or two plates at once
    always @(posedge clk_in) begin
        if ((bp_in == 4'h0 && seg_in != 45'h0) || $countones(bp_in) > 1) begin
            fault_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
/*
 * Self-checking bench for the segment display controller.
 * Assumes one 40 MHz clock, an AHB-Lite master in this module and an
 * auxiliary oscillator made here at one rising edge every 6 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lcd_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic stop = 1'b0;
    logic aux = 1'b0;
    logic fail = 1'b0;
    logic [31:0] hrdata;
    logic hready, hresp, on, fault;
    logic [44:0] seg;
    logic [3:0] bp;
    logic [7:0] mem [24];
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int aux_cnt = 0;

    always #12.5 clk = ~clk;

    // Auxiliary oscillator, period of 6 clocks
    always @(posedge clk) begin
        aux_cnt <= (aux_cnt == 2) ? 0 : aux_cnt + 1;
        if (aux_cnt == 2) aux <= ~aux;
    end

    lcd_segment_controller lcd_segment_controller_i (
        .MCLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .STOP_IN(stop), .AUX_OSC_IN(aux), .OSC_FAIL_IN(fail),
        .SEG_OUT(seg), .BP_OUT(bp), .DISPLAY_ON_OUT(on)
    );

    panel_model panel_model_i (.clk_in(clk), .seg_in(seg), .bp_in(bp), .fault_out(fault));

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            print_verdict;
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata[7:0];
        check({hresp, hrdata[31:8]}, 25'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        check(x, exp);
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Waits for the backplane to move; samples segments 8 cycles in
    task automatic slot(input int lim, input bit chk, input logic [44:0] s, output int n);
        logic [3:0] b;
        b = bp;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n == 8 && chk) check(seg, s);
        end while (bp === b && n < lim);
    endtask

    task automatic start(input logic [7:0] m);
        int n;
        do_reset;
        wr(MODE_IDX, m);
        n = 0;
        while (bp !== 4'h1 && n < 200) begin @(posedge clk); n++; end
        check(bp, 4'h1);
    endtask

    function automatic logic [44:0] row(input int k);
        logic [47:0] r;
        for (int j = 0; j < 6; j++) r[8*j +: 8] = mem[6*k+j];
        return r[47:3];
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd_chk(MODE_IDX, 8'h00);
        wr(MODE_IDX, 8'hDB);
        rd_chk(MODE_IDX, 8'hDB);
        wr(8'hDD, 8'h55);
        rd_chk(8'hDD, 8'h00);
        rd_chk(8'hF8, 8'h00);
    endtask

    task automatic t_ram;
        do_reset;
        wr(MODE_IDX, 8'h40);
        for (int i = 0; i < RAM_BYTES; i++) begin
            mem[i] = 8'(i * 29 + 7);
            wr(RAM_FIRST_IDX + 8'(i), mem[i]);
        end
        for (int i = 0; i < RAM_BYTES; i++) rd_chk(RAM_FIRST_IDX + 8'(i), mem[i]);
        do_reset;
        for (int i = 0; i < RAM_BYTES; i++) rd_chk(RAM_FIRST_IDX + 8'(i), mem[i]);
    endtask

    task automatic t_scan;
        int n;
        start(8'h1E);
        for (int k = 0; k < 5; k++) begin
            slot(2100, 1'b1, row(k % 4), n);
            if (k > 0) check(n, int'(PRE_DIV_3) * int'(FDIV_6));
            check(bp, 4'h1 << ((k + 1) % 4));
        end
    endtask

    task automatic t_mux;
        int n;
        for (int c = 1; c < 4; c++) begin
            start({2'(c), 3'h1, 3'h6});
            for (int k = 0; k <= c; k++) begin
                slot(800, 1'b0, 45'h0, n);
                check(bp, (c == 1) ? 4'h1 : 4'h1 << ((k + 1) % c));
            end
        end
    endtask

    task automatic t_fdiv;
        int fd[7] = '{512, 386, 256, 192, 128, 96, 64};
        int n;
        for (int f = 0; f < 7; f++) begin
            start({5'h01, 3'(f)});
            slot(3200, 1'b0, 45'h0, n);
            slot(3200, 1'b0, 45'h0, n);
            check(n, 6 * fd[f]);
        end
    endtask

    task automatic t_src;
        int n, e;
        for (int s = 4; s < 7; s++) begin
            e = 64 * (32 << (s - 3));
            start({2'h0, 3'(s), 3'h6});
            slot(e + 100, 1'b0, 45'h0, n);
            check(n >= e && n <= e + 8, 1'b1);
        end
    endtask

    task automatic t_stop;
        int n;
        start(8'h1E);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        check({on, bp, seg}, 50'h0);
        stop <= 1'b0;
        wr(MODE_IDX, 8'h0E);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        check({on, bp, seg}, 50'h0);
        stop <= 1'b0;
        repeat (9000) @(posedge clk);
        stop <= 1'b1;
        slot(800, 1'b0, 45'h0, n);
        check({n < 800, on}, 2'h3);
        stop <= 1'b0;
        fail <= 1'b1;
        repeat (5) @(posedge clk);
        check({on, bp, seg}, 50'h0);
        fail <= 1'b0;
    endtask

    task automatic t_bad;
        logic [7:0] m[4] = '{8'h06, 8'h16, 8'h3E, 8'h1F};
        for (int i = 0; i < 4; i++) begin
            do_reset;
            wr(MODE_IDX, m[i]);
            repeat (10) @(posedge clk);
            check(on, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_ram;
        t_scan;
        t_mux;
        t_fdiv;
        t_src;
        t_stop;
        t_bad;
        check(fault, 1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire
